// >>> include/rsios_defines.vh
// constants for the safety and status signal supervisor
`ifndef RSIOS_DEFINES_VH
`define RSIOS_DEFINES_VH

// ----------------------------------------------------------------
// apb register map (byte addresses)
// ----------------------------------------------------------------
`define RSIOS_ADDR_CTRL      12'h000
`define RSIOS_ADDR_STATUS    12'h004
`define RSIOS_ADDR_ZONE_CFG  12'h008
`define RSIOS_ADDR_ZONE_HIT  12'h00c
`define RSIOS_ADDR_SERVICE   12'h010
`define RSIOS_ADDR_EDGE_CLR  12'h014

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define RSIOS_CTRL_SERVO_REQ  0
`define RSIOS_CTRL_ALARM_RST  1
`define RSIOS_CTRL_SYNC_EN    2
`define RSIOS_CTRL_START      3
`define RSIOS_CTRL_RESET      4'h0
`define RSIOS_CTRL_W          4
`define RSIOS_CLR_SKIP        0

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define RSIOS_ST_ESTOP        0
`define RSIOS_ST_GATE_OPEN    1
`define RSIOS_ST_AUTO         2
`define RSIOS_ST_SERVO_ON     3
`define RSIOS_ST_FAULT        4
`define RSIOS_ST_WIRING       5
`define RSIOS_ST_ADC_FAULT    6
`define RSIOS_ST_GATE_LATCH   7
`define RSIOS_ST_RUNNING      8
`define RSIOS_ST_SKIP_HELD    9
`define RSIOS_ST_STATE_LSB    12
`define RSIOS_SVC_HAND_LSB    0
`define RSIOS_SVC_AIR_LSB     4
`define RSIOS_SVC_WARN_LSB    8
`define RSIOS_PAIRS           3
`define RSIOS_ZONES           8

// ----------------------------------------------------------------
// zone configuration: first output in [2:0], last in [6:4]
// ----------------------------------------------------------------
`define RSIOS_ZONE_FIRST_LSB  0
`define RSIOS_ZONE_LAST_LSB   4
`define RSIOS_ZONE_CFG_RESET  8'h70
`define RSIOS_ZONE_CFG_W      8

// ----------------------------------------------------------------
// timing at 50 MHz
// ----------------------------------------------------------------
`define RSIOS_CLK_MHZ         50
`define RSIOS_STOP_US         100000
`define RSIOS_STOP_CYCLES     (`RSIOS_STOP_US * `RSIOS_CLK_MHZ)
`define RSIOS_MISMATCH_US     20000
`define RSIOS_MISMATCH_CYCLES (`RSIOS_MISMATCH_US * `RSIOS_CLK_MHZ)
`define RSIOS_CNT_W           24

`endif

// >>> hdl/rsios_supervisor.v
// safety and status signal supervisor with apb register access
// Notes on behaviour
// - hand fault output follows its request level
// - air pressure fault output follows request level
// - service warning asserted when parts due
// - eight zone outputs within first..last range
// - level inputs act only while on
// - edge inputs latch on off-to-on transition
// - either open halt channel halts; both wired
// - open gate channel in automatic switches servo off
// - two-channel selector chooses manual or automatic
// - fault contact open while any fault
// - halt contact open on external or pendant halt
// - mode contact open manual, closed automatic
// - sync output mirrors arm servo state
// - all contacts open when unpowered or reset
// - stop arm first, then servo off
// - early stop command raises conversion fault
// - single halt channel keeps fault raised
// - auto gate open latches fault; ordered recovery
// - selector open manual, closed automatic
`timescale 1ns/1ps
`include "rsios_defines.vh"

module rsios_supervisor #(
	parameter STOP_CYCLES     = `RSIOS_STOP_CYCLES,
	parameter MISMATCH_CYCLES = `RSIOS_MISMATCH_CYCLES
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        estop_a,
	input  wire        estop_b,
	input  wire        gate_a,
	input  wire        gate_b,
	input  wire        mode_a,
	input  wire        mode_b,
	input  wire        skip_stop,
	input  wire        pendant_halt,
	input  wire        stop_cmd,
	input  wire        servo_off_cmd,
	input  wire        arm_stopped,
	input  wire [2:0]  hand_fault_request,
	input  wire [2:0]  air_pressure_request,
	input  wire [2:0]  parts_due,
	input  wire [7:0]  zone_inside,
	output reg  [2:0]  hand_fault_out,
	output reg  [2:0]  air_pressure_fault,
	output reg  [2:0]  service_due_warning,
	output reg  [7:0]  zone_occupancy_outputs,
	output reg         servo_enable,
	output reg         arm_stop_req,
	output reg         fault_contact,
	output reg         halt_contact,
	output reg         mode_contact,
	output reg         sync_contact
);

	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	localparam ST_OFF      = 4'h1;
	localparam ST_ON       = 4'h2;
	localparam ST_STOPPING = 4'h4;
	localparam ST_LOCKED   = 4'h8;

	reg  [3:0]                state;
	reg  [3:0]                next_state;
	reg  [3:0]                ctrl;
	reg  [7:0]                zone_cfg;
	reg                       gate_latch;
	reg                       adc_fault;
	reg                       wiring_fault;
	reg                       running;
	reg                       skip_held;
	reg                       skip_prev;
	reg                       start_prev;
	reg  [`RSIOS_CNT_W-1:0]   stop_cnt;
	reg  [31:0]               status_word;
	reg  [31:0]               service_word;
	reg  [7:0]                zone_mask;
	integer                   i;

	// ----------------------------------------------------------------
	// decode and channel logic
	// ----------------------------------------------------------------
	wire       wr     = psel && penable && pwrite;
	wire       rd     = psel && !penable && !pwrite;
	wire       wr_ctrl = wr && (paddr == `RSIOS_ADDR_CTRL);
	wire       wr_zone = wr && (paddr == `RSIOS_ADDR_ZONE_CFG);
	wire       wr_clr  = wr && (paddr == `RSIOS_ADDR_EDGE_CLR) && pwdata[`RSIOS_CLR_SKIP];
	wire       halt_ext = !estop_a || !estop_b;
	wire       halt_any = halt_ext || pendant_halt;
	wire       gate_open = !gate_a || !gate_b;
	wire       auto_mode = mode_a && mode_b;
	// channels of the halt, gate and selector pairs, in that order
	wire [2:0] chan_a = {mode_a, gate_a, estop_a};
	wire [2:0] chan_b = {mode_b, gate_b, estop_b};
	wire [2:0] pair_bad = chan_a ^ chan_b;
	wire [2:0] pair_stuck;
	wire       mismatch = |pair_bad;
	// servo stays powered through the braking phase
	wire       servo_next = (next_state == ST_ON) || (next_state == ST_STOPPING);
	wire       single_ch = estop_a ^ estop_b;
	wire       gate_trip = gate_open && auto_mode;
	wire       trip   = halt_any || gate_trip;
	wire [2:0] zfirst = zone_cfg[`RSIOS_ZONE_FIRST_LSB +: 3];
	wire [2:0] zlast  = zone_cfg[`RSIOS_ZONE_LAST_LSB +: 3];
	// hand and pneumatic requests count as faults while they stand
	wire       any_fault = halt_ext || gate_latch || adc_fault || wiring_fault || single_ch
		|| (|hand_fault_request) || (|air_pressure_request);
	wire       start_rise = ctrl[`RSIOS_CTRL_START] && !start_prev;
	// outside stop commands inside this window clash with the trip
	wire       in_window = (stop_cnt != {`RSIOS_CNT_W{1'b0}});

	// every access completes at once; unmapped ones read zero
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			ctrl     <= `RSIOS_CTRL_RESET;
			zone_cfg <= `RSIOS_ZONE_CFG_RESET;
		end else begin
			// alarm reset is a level: while held it keeps clearing latches
			if (wr_ctrl)
				ctrl <= pwdata[`RSIOS_CTRL_W-1:0];
			if (wr_zone)
				zone_cfg <= pwdata[`RSIOS_ZONE_CFG_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// special stop latch
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			skip_prev <= 1'b0;
			skip_held <= 1'b0;
		end else begin
			skip_prev <= skip_stop;
			// latches on a rising edge; software releases it, set wins
			if (skip_stop && !skip_prev)
				skip_held <= 1'b1;
			else if (wr_clr)
				skip_held <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// start latch: a held start bit does not restart
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			start_prev <= 1'b0;
			running    <= 1'b0;
		end else begin
			start_prev <= ctrl[`RSIOS_CTRL_START];
			if (trip || skip_held || state != ST_ON)
				running <= 1'b0;
			else if (start_rise)
				running <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// servo sequencer: stop arm, then drop servo
	// ----------------------------------------------------------------
	always @* begin
		next_state = state;
		case (state)
			ST_OFF: begin
				if (!trip && !gate_latch && ctrl[`RSIOS_CTRL_SERVO_REQ])
					next_state = ST_ON;
			end
			ST_ON: begin
				if (trip)
					next_state = ST_STOPPING;
				else if (!ctrl[`RSIOS_CTRL_SERVO_REQ])
					next_state = ST_OFF;
			end
			ST_STOPPING: begin
				if (arm_stopped)
					next_state = ST_LOCKED;
			end
			ST_LOCKED: begin
				// servo request must be dropped before it may be re-enabled
				if (!trip && !ctrl[`RSIOS_CTRL_SERVO_REQ])
					next_state = ST_OFF;
			end
			default: next_state = ST_OFF;
		endcase
	end

	// a trip in ON leaves the servo on until the arm reports rest
	always @(posedge clk) begin
		if (rst) begin
			state        <= ST_OFF;
			gate_latch   <= 1'b0;
			adc_fault    <= 1'b0;
			wiring_fault <= 1'b0;
			stop_cnt     <= {`RSIOS_CNT_W{1'b0}};
		end else begin
			state <= next_state;
			// gate in automatic latches an alarm; set wins over reset
			if (gate_trip)
				gate_latch <= 1'b1;
			else if (ctrl[`RSIOS_CTRL_ALARM_RST] && !gate_open)
				gate_latch <= 1'b0;
			// window after a trip in which outside stop commands clash
			if (trip && state == ST_ON)
				stop_cnt <= STOP_CYCLES[`RSIOS_CNT_W-1:0];
			else if (in_window)
				stop_cnt <= stop_cnt - 1'b1;
			if (in_window && (stop_cmd || servo_off_cmd))
				adc_fault <= 1'b1;
			else if (ctrl[`RSIOS_CTRL_ALARM_RST])
				adc_fault <= 1'b0;
			if (|pair_stuck)
				wiring_fault <= 1'b1;
			else if (ctrl[`RSIOS_CTRL_ALARM_RST] && !mismatch)
				wiring_fault <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// per-pair disagreement timers
	// ----------------------------------------------------------------
	// one timer per pair, so a flicker on one pair cannot restart the
	// count of another that is really miswired
	genvar g;
	generate
		for (g = 0; g < `RSIOS_PAIRS; g = g + 1) begin : g_pair
			reg [`RSIOS_CNT_W-1:0] cnt;
			always @(posedge clk) begin
				if (rst)
					cnt <= {`RSIOS_CNT_W{1'b0}};
				else if (!pair_bad[g])
					cnt <= {`RSIOS_CNT_W{1'b0}};
				else if (cnt != MISMATCH_CYCLES[`RSIOS_CNT_W-1:0])
					cnt <= cnt + 1'b1;
			end
			assign pair_stuck[g] = pair_bad[g] && (cnt == MISMATCH_CYCLES[`RSIOS_CNT_W-1:0]);
		end
	endgenerate

	// ----------------------------------------------------------------
	// zone allocation and level outputs
	// ----------------------------------------------------------------
	// outputs outside first..last stay low even with the arm inside
	always @* begin
		for (i = 0; i < `RSIOS_ZONES; i = i + 1)
			zone_mask[i] = (i[2:0] >= zfirst) && (i[2:0] <= zlast);
	end

	always @(posedge clk) begin
		if (rst) begin
			hand_fault_out         <= 3'h0;
			air_pressure_fault     <= 3'h0;
			service_due_warning    <= 3'h0;
			zone_occupancy_outputs <= 8'h00;
			servo_enable           <= 1'b0;
			arm_stop_req           <= 1'b0;
		end else begin
			hand_fault_out         <= hand_fault_request;
			air_pressure_fault     <= air_pressure_request;
			service_due_warning    <= parts_due;
			zone_occupancy_outputs <= zone_inside & zone_mask;
			servo_enable           <= servo_next;
			arm_stop_req           <= (next_state == ST_STOPPING) || trip || skip_held;
		end
	end

	// ----------------------------------------------------------------
	// output contacts: high is closed, low is open
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			// contacts open out of reset, as they are when unpowered
			fault_contact <= 1'b0;
			halt_contact  <= 1'b0;
			mode_contact  <= 1'b0;
			sync_contact  <= 1'b0;
		end else begin
			fault_contact <= !any_fault;
			halt_contact  <= !halt_any;
			mode_contact  <= auto_mode;
			sync_contact  <= ctrl[`RSIOS_CTRL_SYNC_EN] && servo_next;
		end
	end

	// ----------------------------------------------------------------
	// read-back words, assembled field by field
	// ----------------------------------------------------------------
	always @* begin
		// unused bits read as zero
		status_word = 32'h0000_0000;
		status_word[`RSIOS_ST_ESTOP]      = halt_any;
		status_word[`RSIOS_ST_GATE_OPEN]  = gate_open;
		status_word[`RSIOS_ST_AUTO]       = auto_mode;
		status_word[`RSIOS_ST_SERVO_ON]   = servo_enable;
		status_word[`RSIOS_ST_FAULT]      = any_fault;
		status_word[`RSIOS_ST_WIRING]     = wiring_fault;
		status_word[`RSIOS_ST_ADC_FAULT]  = adc_fault;
		status_word[`RSIOS_ST_GATE_LATCH] = gate_latch;
		status_word[`RSIOS_ST_RUNNING]    = running;
		status_word[`RSIOS_ST_SKIP_HELD]  = skip_held;
		status_word[`RSIOS_ST_STATE_LSB +: 4] = state;
		service_word = 32'h0000_0000;
		service_word[`RSIOS_SVC_HAND_LSB +: 3] = hand_fault_out;
		service_word[`RSIOS_SVC_AIR_LSB +: 3]  = air_pressure_fault;
		service_word[`RSIOS_SVC_WARN_LSB +: 3] = service_due_warning;
	end

	// ----------------------------------------------------------------
	// apb read data, taken in setup so it stands in the access phase
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (rd) begin
			case (paddr)
				`RSIOS_ADDR_CTRL:     prdata <= {28'h0, ctrl};
				`RSIOS_ADDR_STATUS:   prdata <= status_word;
				`RSIOS_ADDR_ZONE_CFG: prdata <= {24'h0, zone_cfg};
				`RSIOS_ADDR_ZONE_HIT: prdata <= {24'h0, zone_occupancy_outputs};
				`RSIOS_ADDR_SERVICE:  prdata <= service_word;
				default:              prdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule // rsios_supervisor

// >>> testbench/rsios_arm_model.sv
// arm model: reports rest some cycles after a stop request
`timescale 1ns/1ps
module rsios_arm_model #(
	parameter DLY = 6
) (
	input  wire clk,
	input  wire arm_stop_req,
	output reg  arm_stopped = 1'h0
);
	integer n = 0;
	// a real arm brakes for a while, so the servo must be kept meanwhile
	always @(posedge clk) begin
		n <= arm_stop_req ? n + 1 : 0;
		arm_stopped <= arm_stop_req && n >= DLY;
	end
endmodule // rsios_arm_model

// >>> testbench/rsios_asserts.sv
// assertions for the safety signal supervisor
`timescale 1ns/1ps
module rsios_asserts (
	input wire       clk,
	input wire       rst,
	input wire       estop_a,
	input wire       estop_b,
	input wire       pendant_halt,
	input wire       mode_a,
	input wire       mode_b,
	input wire       arm_stopped,
	input wire [2:0] hand_fault_request,
	input wire [2:0] air_pressure_request,
	input wire [2:0] parts_due,
	input wire [7:0] zone_inside,
	input wire [2:0] hand_fault_out,
	input wire [2:0] air_pressure_fault,
	input wire [2:0] service_due_warning,
	input wire [7:0] zone_occupancy_outputs,
	input wire       servo_enable,
	input wire       arm_stop_req,
	input wire       fault_contact,
	input wire       halt_contact,
	input wire       mode_contact
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	hand_copy_a: assert property (!$past(rst) |-> hand_fault_out == $past(hand_fault_request))
		else $error("hand fault output off its request");
	air_copy_a: assert property (!$past(rst) |-> air_pressure_fault == $past(air_pressure_request))
		else $error("air fault output off its request");
	service_copy_a: assert property (!$past(rst) |-> service_due_warning == $past(parts_due))
		else $error("service warning off its cause");
	zone_inside_a: assert property (!$past(rst) |-> (zone_occupancy_outputs & ~$past(zone_inside)) == 8'h00)
		else $error("zone output without arm inside");
	halt_open_a: assert property (!estop_a || !estop_b || pendant_halt |=> !halt_contact)
		else $error("halt contact closed during halt");
	single_chan_a: assert property (estop_a != estop_b |=> !fault_contact)
		else $error("fault contact closed on one halt channel");
	mode_follow_a: assert property (!$past(rst) |-> mode_contact == $past(mode_a && mode_b))
		else $error("mode contact off selector");
	servo_kept_a: assert property ((!estop_a || !estop_b || pendant_halt) && servo_enable && !arm_stopped |=> servo_enable)
		else $error("servo off before arm at rest");
	cover property (arm_stop_req && !arm_stopped);
	cover property (mode_contact);
	cover property (|zone_occupancy_outputs);
endmodule // rsios_asserts
bind rsios_supervisor rsios_asserts i_chk (.*);

// >>> testbench/robot_safety_io_supervisor_tb.sv
// self-checking bench for the safety signal supervisor
`timescale 1ns/1ps
`include "rsios_defines.vh"
module robot_safety_io_supervisor_tb;
	reg         clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	reg  [11:0] paddr = 12'h0;
	reg  [31:0] pwdata = 32'h0, rd;
	reg         err;
	reg         estop_a = 1'h1, estop_b = 1'h1, gate_a = 1'h1, gate_b = 1'h1, mode_a = 1'h1, mode_b = 1'h1;
	reg         skip_stop = 1'h0, pendant_halt = 1'h0, stop_cmd = 1'h0, servo_off_cmd = 1'h0;
	reg  [2:0]  hand_fault_request = 3'h0, air_pressure_request = 3'h0, parts_due = 3'h0;
	reg  [7:0]  zone_inside = 8'h0;
	wire        pready, pslverr, arm_stopped, arm_stop_req, servo_enable;
	wire        fault_contact, halt_contact, mode_contact, sync_contact;
	wire [31:0] prdata;
	wire [2:0]  hand_fault_out, air_pressure_fault, service_due_warning;
	wire [7:0]  zone_occupancy_outputs;
	integer     error_cnt = 0, n_compared = 0, cyc = 0, i;
	rsios_supervisor #(.STOP_CYCLES(20), .MISMATCH_CYCLES(10)) i_dut (.*);
	rsios_arm_model i_arm (.*);
	always #10 clk = ~clk;
	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task conclude;
		begin
			if (error_cnt == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			conclude;
		end
	end
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("unexpected %0s: expected %h, seen %h", nm, e, g);
			end
		end
	endtask
	// entered just after an edge; leaves one idle cycle between transfers
	task xfer(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'h1;
			@(posedge clk);
			while (pready !== 1'h1)
				@(posedge clk);
			rd = prdata;
			err = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge clk);
		end
	endtask
	task stat_bit(input string nm, input integer b, input [31:0] e);
		begin
			xfer(1'h0, `RSIOS_ADDR_STATUS, 32'h0);
			chk(nm, e, rd[b]);
		end
	endtask
	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		tick(16);
		chk("contacts", 4'h0, {fault_contact, halt_contact, mode_contact, sync_contact});
		rst <= 1'h0;
		@(posedge clk);
		xfer(1'h0, `RSIOS_ADDR_ZONE_CFG, 32'h0);
		chk("zone cfg", 32'h70, rd);
		xfer(1'h1, 12'h0f0, 32'hffffffff);
		chk("slverr", 1'h0, err);
		xfer(1'h0, 12'h0f0, 32'h0);
		chk("unmapped", 32'h0, rd);
		for (i = 0; i < 8; i = i + 1) begin
			hand_fault_request <= i[2:0];
			air_pressure_request <= ~i[2:0];
			parts_due <= i[2:0] ^ 3'h5;
			zone_inside <= 8'hff >> i;
			tick(2);
			chk("levels", {i[2:0], ~i[2:0], i[2:0] ^ 3'h5}, {hand_fault_out, air_pressure_fault, service_due_warning});
			chk("zones", 8'hff >> i, zone_occupancy_outputs);
		end
		hand_fault_request <= 3'h0;
		zone_inside <= 8'hff;
		xfer(1'h1, `RSIOS_ADDR_ZONE_CFG, 32'h52);
		xfer(1'h0, `RSIOS_ADDR_ZONE_HIT, 32'h0);
		chk("zone range", 32'h3c, rd);
		mode_a <= 1'h0;
		tick(2);
		chk("manual", 1'h0, mode_contact);
		mode_a <= 1'h1;
		tick(2);
		chk("auto", 1'h1, mode_contact);
		xfer(1'h1, `RSIOS_ADDR_CTRL, 32'h5);
		tick(2);
		chk("servo on", 4'hf, {servo_enable, sync_contact, halt_contact, fault_contact});
		// one halt channel opens with an early stop command on purpose
		estop_a <= 1'h0;
		stop_cmd <= 1'h1;
		tick(2);
		chk("stopping", 4'hc, {arm_stop_req, servo_enable, halt_contact, fault_contact});
		stop_cmd <= 1'h0;
		tick(10);
		chk("halted", 1'h0, servo_enable);
		stat_bit("adc", 6, 1);
		stat_bit("wiring", 5, 1);
		estop_a <= 1'h1;
		xfer(1'h1, `RSIOS_ADDR_CTRL, 32'h4);
		xfer(1'h1, `RSIOS_ADDR_CTRL, 32'h5);
		tick(2);
		chk("servo back", 1'h1, servo_enable);
		gate_b <= 1'h0;
		tick(12);
		chk("gate off", 2'h0, {servo_enable, sync_contact});
		stat_bit("gate latch", 7, 1);
		gate_b <= 1'h1;
		xfer(1'h1, `RSIOS_ADDR_CTRL, 32'h6);
		stat_bit("gate clear", 7, 0);
		pendant_halt <= 1'h1;
		tick(2);
		chk("pendant", 1'h0, halt_contact);
		pendant_halt <= 1'h0;
		skip_stop <= 1'h1;
		tick(2);
		skip_stop <= 1'h0;
		tick(2);
		stat_bit("skip held", 9, 1);
		xfer(1'h1, `RSIOS_ADDR_EDGE_CLR, 32'h1);
		stat_bit("skip clear", 9, 0);
		xfer(1'h1, `RSIOS_ADDR_CTRL, 32'h5);
		xfer(1'h1, `RSIOS_ADDR_CTRL, 32'hd);
		stat_bit("running", 8, 1);
		// halt, then a stop command only after the clash window has passed
		estop_a <= 1'h0;
		tick(40);
		stop_cmd <= 1'h1;
		tick(2);
		stop_cmd <= 1'h0;
		stat_bit("late stop", 6, 0);
		stat_bit("run dropped", 8, 0);
		estop_a <= 1'h1;
		tick(2);
		conclude;
	end
endmodule // robot_safety_io_supervisor_tb
